// [hdl/spbs_map.svh]
// Purpose : Named constants for the split-port burst memory pin block
// Assumes : Included by the package and by every design file that needs them
// Notes   : Storage depth is reduced; only low address bits index the array
`ifndef SPBS_MAP_SVH
`define SPBS_MAP_SVH

// ****************************************************************
// Widths
// ****************************************************************
`define SPBS_ADDR_W   21
`define SPBS_DATA_W   36
`define SPBS_LANES    4
`define SPBS_LANE_W   9
`define SPBS_NIBS     2
`define SPBS_NIB_W    4
`define SPBS_BEAT_W   2
`define SPBS_LAST_BEAT 2'h3

// ****************************************************************
// Address widths per configuration
// ****************************************************************
`define SPBS_AW_NARROW 21
`define SPBS_AW_X18    20
`define SPBS_AW_X36    19

// ****************************************************************
// Lane maps per configuration
// ****************************************************************
`define SPBS_LANES_X9  4'h1
`define SPBS_LANES_X18 4'h3
`define SPBS_LANES_X36 4'hF

// ****************************************************************
// Storage model and read pipeline
// ****************************************************************
`define SPBS_MEM_AW   8
`define SPBS_DL_DEPTH 5
`define SPBS_TAP_PLL  4
`define SPBS_TAP_NOPLL 1

`endif

// [hdl/spbs_pkg.sv]
// Purpose : Types shared by the split-port burst memory pin block
// Assumes : Constants come from spbs_map.svh
// Notes   : Types only
`include "spbs_map.svh"
package spbs_pkg;

  // Configured word width, caught at reset release
  typedef enum logic [1:0] {SPBS_W8, SPBS_W9, SPBS_W18, SPBS_W36} spbs_width_t;

  // Which port owns the current true clock edge
  typedef enum logic {SPBS_SLOT_RD, SPBS_SLOT_WR} spbs_slot_t;

endpackage

// [hdl/spbs_mem.sv]
// Purpose : Burst word store with per-bit write enable
// Assumes : One write per clock, read is combinational
// Notes   : No reset; contents are undefined until written
`include "spbs_map.svh"
module spbs_mem
  import spbs_pkg::*;
(
  input  wire logic                                   ref_clk_i,
  input  wire logic                                   we_i,
  input  wire logic [`SPBS_MEM_AW+`SPBS_BEAT_W-1:0]   waddr_i,
  input  wire logic [`SPBS_DATA_W-1:0]                wdata_i,
  input  wire logic [`SPBS_DATA_W-1:0]                wbe_i,
  input  wire logic [`SPBS_MEM_AW+`SPBS_BEAT_W-1:0]   raddr_i,
  output logic      [`SPBS_DATA_W-1:0]                rdata_o
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  // One entry per word of every burst
  logic [`SPBS_DATA_W-1:0] mem [0:(1<<(`SPBS_MEM_AW+`SPBS_BEAT_W))-1];

  // Masked write keeps unselected bits as they were
  always_ff @(posedge ref_clk_i)
  begin
    if (we_i)
    begin
      mem[waddr_i] <= (mem[waddr_i] & ~wbe_i) | (wdata_i & wbe_i);
    end
  end

  // Read is combinational; the caller registers it
  assign rdata_o = mem[raddr_i];

endmodule // spbs_mem

// [hdl/spbs_io.sv]
// Purpose : Pin-level behaviour of a split read/write burst memory
// Assumes : Each ref_clk_i edge is one half cycle; even edges are true clock
//           edges, odd edges complementary ones, counted from reset release
// Notes   : True edges alternate read slot and write slot
`include "spbs_map.svh"

// Functional notes
// - Capture write words on every half edge
// - Low write select on true edge starts write
// - High write select ignores write data
// - Nibble enables cover bits 3:0 and 7:4
// - Inactive nibble enable blocks that nibble
// - Byte enable n guards 9-bit lane n
// - Inactive lane enable keeps stored lane
// - Enables sampled with their own data beat
// - Shared address sampled on true edges only
// - Address width 21, 20 or 19 bits
// - Address ignored when port not selected
// - Read words launched every half edge
// - Deselected read port floats outputs
// - Output width follows configured word width
// - Low read select starts four-word read burst
// - Valid flag marks read data words
module spbs_io
  import spbs_pkg::*;
(
  input  wire logic                        ref_clk_i,
  input  wire logic                        nrst_i,
  input  wire spbs_width_t                 width_mode_i,
  input  wire logic                        pll_disable_n_i,
  input  wire logic                        read_port_select_n_i,
  input  wire logic                        write_port_select_n_i,
  input  wire logic [`SPBS_ADDR_W-1:0]     addr_i,
  input  wire logic [`SPBS_DATA_W-1:0]     wdata_i,
  input  wire logic [`SPBS_NIBS-1:0]       nibble_write_enable_n_i,
  input  wire logic [`SPBS_LANES-1:0]      byte_lane_enable_n_i,
  output logic      [`SPBS_DATA_W-1:0]     q_o,
  output logic      [`SPBS_DATA_W-1:0]     q_oe_o,
  output logic                             read_valid_flag_o,
  output logic                             k_edge_o,
  output logic                             read_slot_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  spbs_width_t                        mode_q;      // Width strap
  logic                               pll_on_q;    // Latency strap
  logic                               kbar_q;      // High on complementary edges
  spbs_slot_t                         slot_q;      // Owner of next true edge
  logic                               k_edge;      // This edge is a true edge
  logic                               rd_take;     // Read accepted now
  logic                               wr_take;     // Write accepted now
  logic [`SPBS_ADDR_W-1:0]            amask;       // Usable address bits
  logic [`SPBS_ADDR_W-1:0]            addr_m;      // Masked address
  logic                               wr_busy_q;   // Beats 1..3 pending
  logic [`SPBS_BEAT_W-1:0]            wr_cnt_q;    // Next write beat
  logic [`SPBS_ADDR_W-1:0]            wr_addr_q;   // Held write address
  logic [`SPBS_BEAT_W-1:0]            wr_beat;     // Beat being written
  logic [`SPBS_ADDR_W-1:0]            wr_addr;     // Address being written
  logic                               mem_we;      // Array write strobe
  logic [`SPBS_LANES-1:0]             lane_on;     // Lanes present in mode
  logic [`SPBS_DATA_W-1:0]            nib_ok;      // Bit enables, x8 mode
  logic [`SPBS_DATA_W-1:0]            lane_ok;     // Bit enables, lane modes
  logic [`SPBS_DATA_W-1:0]            out_on;      // Bits that exist in mode
  logic [`SPBS_DATA_W-1:0]            bit_en;      // Final write mask
  logic [`SPBS_DL_DEPTH-1:0]          dl_q;        // Read request delay line
  logic [`SPBS_ADDR_W-1:0]            dl_addr_q [`SPBS_DL_DEPTH];
  logic                               rd_load;     // Burst starts now
  logic [`SPBS_ADDR_W-1:0]            rd_load_addr;
  logic                               rd_busy_q;   // Words 1..3 pending
  logic [`SPBS_BEAT_W-1:0]            rd_cnt_q;    // Next read word
  logic [`SPBS_ADDR_W-1:0]            rd_addr_q;   // Held read address
  logic [`SPBS_BEAT_W-1:0]            rd_beat;     // Word being read
  logic [`SPBS_ADDR_W-1:0]            rd_addr;     // Address being read
  logic                               rd_drive;    // A word leaves this edge
  logic [`SPBS_DATA_W-1:0]            rdata;       // Array read data
  logic [`SPBS_DATA_W-1:0]            q_q;         // Output word register
  logic                               vld_q;       // Output valid register

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  // ****************************************************************
  // Straps and edge phase
  // ****************************************************************
  // Straps are caught while reset is held; they change nothing mid-run
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      mode_q   <= width_mode_i;
      pll_on_q <= pll_disable_n_i;
    end
  end

  // Half-edge phase: first edge after release is a true edge
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
      kbar_q <= 1'b0;
    else
      kbar_q <= ~kbar_q;
  end

  assign k_edge = ~kbar_q;

  // Slot flips on every true edge; read slot comes first
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
      slot_q <= SPBS_SLOT_RD;
    else if (k_edge)
    begin
      case (slot_q)
        SPBS_SLOT_RD: slot_q <= SPBS_SLOT_WR;
        SPBS_SLOT_WR: slot_q <= SPBS_SLOT_RD;
        default:      slot_q <= SPBS_SLOT_RD;
      endcase
    end
  end

  assign k_edge_o    = k_edge;
  assign read_slot_o = k_edge && (slot_q == SPBS_SLOT_RD);

  // Selects count only on the true edge of their own slot
  assign rd_take = read_slot_o && !read_port_select_n_i;
  assign wr_take = k_edge && (slot_q == SPBS_SLOT_WR) && !write_port_select_n_i;

  // ****************************************************************
  // Address
  // ****************************************************************
  // Wider words need fewer address bits
  always_comb
  begin
    case (mode_q)
      SPBS_W18: amask = `SPBS_ADDR_W'((1 << `SPBS_AW_X18) - 1);
      SPBS_W36: amask = `SPBS_ADDR_W'((1 << `SPBS_AW_X36) - 1);
      default:  amask = `SPBS_ADDR_W'((1 << `SPBS_AW_NARROW) - 1);
    endcase
  end

  assign addr_m = addr_i & amask;

  // ****************************************************************
  // Write burst
  // ****************************************************************
  // Address latched only on an accepted true edge
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      wr_busy_q <= 1'b0;
      wr_cnt_q  <= '0;
      wr_addr_q <= '0;
    end
    else if (wr_take)
    begin
      wr_busy_q <= 1'b1;
      wr_cnt_q  <= `SPBS_BEAT_W'(1);
      wr_addr_q <= addr_m;
    end
    else if (wr_busy_q)
    begin
      wr_cnt_q  <= wr_cnt_q + `SPBS_BEAT_W'(1);
      wr_busy_q <= (wr_cnt_q != `SPBS_LAST_BEAT);
    end
  end

  // Beat 0 travels with the select; later beats on each half edge
  assign wr_beat = wr_take ? '0 : wr_cnt_q;
  assign wr_addr = wr_take ? addr_m : wr_addr_q;
  assign mem_we  = wr_take || wr_busy_q;

  // ****************************************************************
  // Write mask
  // ****************************************************************
  always_comb
  begin
    case (mode_q)
      SPBS_W9:  lane_on = `SPBS_LANES_X9;
      SPBS_W18: lane_on = `SPBS_LANES_X18;
      default:  lane_on = `SPBS_LANES_X36;
    endcase
  end

  // Enables are used on the very edge that carries their beat
  for (genvar g = 0; g < `SPBS_DATA_W; g++)
  begin : g_bit
    if (g < `SPBS_NIBS * `SPBS_NIB_W)
    begin : g_nib
      assign nib_ok[g] = !nibble_write_enable_n_i[g / `SPBS_NIB_W];
    end
    else
    begin : g_nonib
      assign nib_ok[g] = 1'b0;
    end
    assign lane_ok[g] = lane_on[g / `SPBS_LANE_W]
                        && !byte_lane_enable_n_i[g / `SPBS_LANE_W];
    assign out_on[g]  = (mode_q == SPBS_W8) ? (g < `SPBS_NIBS * `SPBS_NIB_W)
                                            : lane_on[g / `SPBS_LANE_W];
  end

  assign bit_en = (mode_q == SPBS_W8) ? nib_ok : lane_ok;

  // ****************************************************************
  // Storage
  // ****************************************************************
  spbs_mem u_mem (
    .ref_clk_i (ref_clk_i),
    .we_i      (mem_we),
    .waddr_i   ({wr_addr[`SPBS_MEM_AW-1:0], wr_beat}),
    .wdata_i   (wdata_i),
    .wbe_i     (bit_en),
    .raddr_i   ({rd_addr[`SPBS_MEM_AW-1:0], rd_beat}),
    .rdata_o   (rdata)
  );

  // ****************************************************************
  // Read pipeline
  // ****************************************************************
  // Delay line holds accepted reads until their latency has run
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
      dl_q <= '0;
    else
      dl_q <= {dl_q[`SPBS_DL_DEPTH-2:0], rd_take};
  end

  always_ff @(posedge ref_clk_i)
  begin
    dl_addr_q[0] <= addr_m;
    for (int i = 1; i < `SPBS_DL_DEPTH; i++)
      dl_addr_q[i] <= dl_addr_q[i-1];
  end

  // Tap chosen by the PLL strap
  assign rd_load      = pll_on_q ? dl_q[`SPBS_TAP_PLL] : dl_q[`SPBS_TAP_NOPLL];
  assign rd_load_addr = pll_on_q ? dl_addr_q[`SPBS_TAP_PLL]
                                 : dl_addr_q[`SPBS_TAP_NOPLL];

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      rd_busy_q <= 1'b0;
      rd_cnt_q  <= '0;
      rd_addr_q <= '0;
    end
    else if (rd_load)
    begin
      rd_busy_q <= 1'b1;
      rd_cnt_q  <= `SPBS_BEAT_W'(1);
      rd_addr_q <= rd_load_addr;
    end
    else if (rd_busy_q)
    begin
      rd_cnt_q  <= rd_cnt_q + `SPBS_BEAT_W'(1);
      rd_busy_q <= (rd_cnt_q != `SPBS_LAST_BEAT);
    end
  end

  assign rd_beat  = rd_load ? '0 : rd_cnt_q;
  assign rd_addr  = rd_load ? rd_load_addr : rd_addr_q;
  assign rd_drive = rd_load || rd_busy_q;

  // ****************************************************************
  // Output drive
  // ****************************************************************
  // Output is zero when idle so a floating bus never shows stale words
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      q_q   <= '0;
      vld_q <= 1'b0;
    end
    else if (rd_drive)
    begin
      q_q   <= rdata & out_on;
      vld_q <= 1'b1;
    end
    else
    begin
      q_q   <= '0;
      vld_q <= 1'b0;
    end
  end

  assign q_o               = q_q;
  assign q_oe_o            = vld_q ? out_on : '0;
  assign read_valid_flag_o = vld_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_burst;
    read_valid_flag_o [*4];
  endsequence

  a_read_lat_pll:  assert property (rd_take && pll_on_q |-> ##6 s_burst)
    else $error("read burst not at 2.5 cycle latency");
  a_read_lat_off:  assert property (rd_take && !pll_on_q |-> ##3 s_burst)
    else $error("read burst not at short latency");
  a_write_beats:   assert property (wr_take |-> mem_we [*4])
    else $error("write burst not four beats");
  a_write_ignore:  assert property (!wr_take && !wr_busy_q |-> !mem_we)
    else $error("write without select");
  a_nibble_mask:   assert property (mode_q == SPBS_W8 && nibble_write_enable_n_i[0]
                     |-> bit_en[3:0] == '0 && bit_en[35:8] == '0)
    else $error("masked nibble written");
  a_lane_mask:     assert property (mode_q != SPBS_W8 && byte_lane_enable_n_i[1]
                     |-> bit_en[17:9] == '0)
    else $error("masked lane written");
  a_float_idle:    assert property ($fell(read_valid_flag_o) |-> q_oe_o == '0 && q_o == '0
                     ##1 !read_valid_flag_o || $past(rd_drive))
    else $error("outputs driven after burst");
  a_slot_split:    assert property (rd_take |-> !wr_take ##4 !wr_take)
    else $error("read and write share a slot");
  a_width_x18:     assert property (mode_q == SPBS_W18 |-> q_oe_o[35:18] == '0)
    else $error("unused output bits driven");

endmodule // spbs_io

// [verification/spbs_ctrl_model.sv]
// Purpose : Memory controller model that drives the burst memory pins
// Assumes : Edges are counted from reset release; edge 4k read slot, 4k+2 write
// Notes   : Released address and data lines show the inverse of their last value; selects go high, enables off
`include "spbs_map.svh"
module spbs_ctrl_model
  import spbs_pkg::*;
(
  input  wire logic                    ref_clk_i,
  input  wire logic                    nrst_i,
  input  wire logic [`SPBS_DATA_W-1:0] q_i,
  input  wire logic [`SPBS_DATA_W-1:0] q_oe_i,
  input  wire logic                    valid_i,
  output logic                         rd_sel_n_o,
  output logic                         wr_sel_n_o,
  output logic      [`SPBS_ADDR_W-1:0] addr_o,
  output logic      [`SPBS_DATA_W-1:0] wdata_o,
  output logic      [`SPBS_NIBS-1:0]   nib_n_o,
  output logic      [`SPBS_LANES-1:0]  lane_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Slot tracking and capture
  // ****************************************************************
  int unsigned              edge_q;   // Index of the coming edge
  logic [`SPBS_DATA_W-1:0]  words_q[$]; // Valid words seen
  logic [`SPBS_DATA_W-1:0]  oe_q[$];    // Their output enables
  int                       at_q[$];    // Edge each was seen on

  // Idle pins at time zero: selects high, enables off
  initial
  begin
    rd_sel_n_o = 1'b1;
    wr_sel_n_o = 1'b1;
    addr_o = '0;
    wdata_o = '0;
    nib_n_o = '1;
    lane_n_o = '1;
  end

  // Edge counter restarts on reset so slots match the device
  always_ff @(posedge ref_clk_i)
    edge_q <= nrst_i ? edge_q + 1 : 0;

  // Capture every word flagged valid, with its edge index
  always @(posedge ref_clk_i)
    if (valid_i === 1'b1)
    begin
      words_q.push_back(q_i);
      oe_q.push_back(q_oe_i);
      at_q.push_back(edge_q);
    end

  // Always lets one edge pass first, so no pin changes twice at once
  task automatic to_slot(input logic [1:0] ph);
    @(negedge ref_clk_i);
    while (edge_q[1:0] != ph) @(negedge ref_clk_i);
  endtask

  // Four-beat write; each enable travels with its own beat
  task automatic wr(input logic [20:0] a, input logic [3:0][35:0] w,
                    input logic [3:0][3:0] ln, input logic [3:0][1:0] nb, input logic sn);
    to_slot(2'h2);
    wr_sel_n_o = sn;
    addr_o = a;
    for (int i = 0; i < 4; i++)
    begin
      if (i > 0) @(negedge ref_clk_i);
      if (i == 1) wr_sel_n_o = 1'b1;
      if (i == 1) addr_o = ~addr_o;
      wdata_o = w[i];
      lane_n_o = ln[i];
      nib_n_o = nb[i];
    end
    @(negedge ref_clk_i);
    wdata_o = ~wdata_o;
    lane_n_o = '1;
    nib_n_o = '1;
  endtask

  // One read request held for one true edge
  task automatic rd(input logic [20:0] a, input logic sn, output int take);
    to_slot(2'h0);
    take = edge_q;
    rd_sel_n_o = sn;
    addr_o = a;
    @(negedge ref_clk_i);
    rd_sel_n_o = 1'b1;
    addr_o = ~addr_o;
  endtask
endmodule // spbs_ctrl_model

// [verification/spbs_io_tb_top.sv]
// Purpose : Self-checking bench for the split-port burst memory pins
// Assumes : The controller model drives requests at falling edges
// Notes   : Storage is shallow, so addresses stay below 8'hFF
`include "spbs_map.svh"
module spbs_io_tb_top
  import spbs_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Stimulus data and wiring
  // ****************************************************************
  localparam logic [20:0] A = 21'h00005; // First burst address
  localparam logic [20:0] B = 21'h000A3; // Second burst address
  localparam logic [3:0][35:0] WA = {36'hA1B2C3D4E, 36'h5F6071829, 36'h3A4B5C6D7, 36'h9E8F7A6B5};
  localparam logic [3:0][35:0] WB = {36'h0F1E2D3C4, 36'hB5A697887, 36'h6C7D8E9FA, 36'h123456789};
  logic              ref_clk, nrst_n, pll_dis_n, rd_n, wr_n, vld, k_edge, rslot;
  spbs_width_t       mode;        // Width strap
  logic [20:0]       addr;        // Shared address
  logic [35:0]       wdata, q, q_oe;
  logic [1:0]        nib_n;
  logic [3:0]        lane_n;
  logic [3:0][35:0]  exp_a;       // What address A should now hold
  int                fails = 0;
  int                n_tests = 0;

  spbs_io spbs_io_inst (.ref_clk_i(ref_clk), .nrst_i(nrst_n), .width_mode_i(mode),
    .pll_disable_n_i(pll_dis_n), .read_port_select_n_i(rd_n),
    .write_port_select_n_i(wr_n), .addr_i(addr), .wdata_i(wdata),
    .nibble_write_enable_n_i(nib_n), .byte_lane_enable_n_i(lane_n), .q_o(q),
    .q_oe_o(q_oe), .read_valid_flag_o(vld), .k_edge_o(k_edge), .read_slot_o(rslot));
  spbs_ctrl_model spbs_ctrl_model_inst (.ref_clk_i(ref_clk), .nrst_i(nrst_n), .q_i(q),
    .q_oe_i(q_oe), .valid_i(vld), .rd_sel_n_o(rd_n), .wr_sel_n_o(wr_n), .addr_o(addr),
    .wdata_o(wdata), .nib_n_o(nib_n), .lane_n_o(lane_n));

  // 4 ns clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Compare and count
  task automatic check(input string what, input logic [35:0] got, input logic [35:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Twelve cycles of reset with the straps set
  task automatic do_reset(input spbs_width_t md, input logic pd);
    @(negedge ref_clk);
    nrst_n = 1'b0;
    mode = md;
    pll_dis_n = pd;
    repeat (12) @(negedge ref_clk);
    check("idle enable", q_oe, '0);
    check("idle valid", 36'(vld), '0);
    check("reset slot", 36'({k_edge, rslot}), 36'h3);
    nrst_n = 1'b1;
    // Edge 0 was a true read-slot edge, so the next one is complementary
    @(negedge ref_clk);
    check("half edge", 36'({k_edge, rslot}), 36'h0);
  endtask

  // Pops one burst of four captured words and checks their timing
  task automatic expect_rd(input int take, input int lat, input logic [3:0][35:0] w,
                           input logic [35:0] oe);
    for (int i = 0; i < 4; i++)
    begin
      if (spbs_ctrl_model_inst.words_q.size() == 0)
      begin
        check("word count", 36'(i), 36'h4);
        return;
      end
      check("read word", spbs_ctrl_model_inst.words_q.pop_front(), w[i]);
      check("out enable", spbs_ctrl_model_inst.oe_q.pop_front(), oe);
      check("word edge", 36'(spbs_ctrl_model_inst.at_q.pop_front()), 36'(take + lat + i));
    end
    check("float after", q_oe, '0);
    check("float data", q, '0);
  endtask

  // Full write, then read at 2.5 cycle latency
  task automatic t_basic();
    int tk;
    do_reset(SPBS_W36, 1'b1);
    spbs_ctrl_model_inst.wr(A, WA, '0, '0, 1'b0);
    spbs_ctrl_model_inst.rd(A, 1'b0, tk);
    repeat (10) @(negedge ref_clk);
    expect_rd(tk, 6, WA, 36'hFFFFFFFFF);
    $display("basic burst done");
  endtask

  // Beat i leaves lane i alone; the old lane must survive
  task automatic t_lanes();
    int tk;
    for (int i = 0; i < 4; i++)
      exp_a[i] = (WB[i] & ~(36'h1FF << (9 * i))) | (WA[i] & (36'h1FF << (9 * i)));
    spbs_ctrl_model_inst.wr(A, WB, {4'h8, 4'h4, 4'h2, 4'h1}, '0, 1'b0);
    spbs_ctrl_model_inst.rd(A, 1'b0, tk);
    repeat (10) @(negedge ref_clk);
    expect_rd(tk, 6, exp_a, 36'hFFFFFFFFF);
    $display("lane mask done");
  endtask

  // Deselected ports: no store, no output
  task automatic t_desel();
    int tk;
    spbs_ctrl_model_inst.wr(A, WA, '0, '0, 1'b1);
    spbs_ctrl_model_inst.rd(A, 1'b1, tk);
    repeat (10) @(negedge ref_clk);
    check("desel words", 36'(spbs_ctrl_model_inst.words_q.size()), '0);
    spbs_ctrl_model_inst.rd(A, 1'b0, tk);
    repeat (10) @(negedge ref_clk);
    expect_rd(tk, 6, exp_a, 36'hFFFFFFFFF);
    $display("deselect done");
  endtask

  // Two reads in consecutive read slots stream without a gap
  task automatic t_b2b();
    int tk;
    int t2;
    spbs_ctrl_model_inst.wr(B, WA, '0, '0, 1'b0);
    spbs_ctrl_model_inst.rd(A, 1'b0, tk);
    spbs_ctrl_model_inst.rd(B, 1'b0, t2);
    repeat (10) @(negedge ref_clk);
    check("slot gap", 36'(t2 - tk), 36'h4);
    expect_rd(tk, 6, exp_a, 36'hFFFFFFFFF);
    expect_rd(t2, 6, WA, 36'hFFFFFFFFF);
    $display("back to back done");
  endtask

  // Narrow lane modes: lane 1 held off, lanes beyond the mode neither stored nor driven
  task automatic t_narrow(input spbs_width_t md, input logic [35:0] oe);
    int tk;
    logic [3:0][35:0] ex;
    do_reset(md, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      exp_a[i] = (WB[i] & 36'h0000001FF) | (exp_a[i] & ~36'h0000001FF);
      ex[i] = exp_a[i] & oe;
    end
    spbs_ctrl_model_inst.wr(A, WB, {4'h2, 4'h2, 4'h2, 4'h2}, '0, 1'b0);
    spbs_ctrl_model_inst.rd(A, 1'b0, tk);
    repeat (10) @(negedge ref_clk);
    expect_rd(tk, 6, ex, oe);
    $display("narrow lanes done");
  endtask

  // Byte-wide mode, short latency, nibble masks per beat
  task automatic t_nibble();
    int tk;
    logic [3:0][1:0] nb;
    logic [3:0][35:0] ex;
    logic [7:0] wm;
    nb = {2'b00, 2'b11, 2'b10, 2'b01};
    do_reset(SPBS_W8, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      wm = {nb[i][1] ? 4'h0 : 4'hF, nb[i][0] ? 4'h0 : 4'hF};
      ex[i] = {28'h0, (WB[i][7:0] & wm) | (WA[i][7:0] & ~wm)};
    end
    spbs_ctrl_model_inst.wr(B, WA, '0, '0, 1'b0);
    spbs_ctrl_model_inst.wr(B, WB, '0, nb, 1'b0);
    spbs_ctrl_model_inst.rd(B, 1'b0, tk);
    repeat (10) @(negedge ref_clk);
    expect_rd(tk, 3, ex, 36'h0000000FF);
    $display("nibble mask done");
  endtask

  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    nrst_n = 1'b0;
    mode = SPBS_W36;
    pll_dis_n = 1'b1;
    t_basic();
    t_lanes();
    t_desel();
    t_b2b();
    t_narrow(SPBS_W18, 36'h00003FFFF);
    t_narrow(SPBS_W9, 36'h0000001FF);
    t_nibble();
    results();
  end

  // Watchdog: tests need well under a thousand cycles
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    fails++;
    results();
  end
endmodule // spbs_io_tb_top
